// ===== rtl/amtt_defs.svh
`ifndef AMTT_DEFS_SVH
`define AMTT_DEFS_SVH

// register offsets
`define AMTT_ADDR_ALARM_STATUS_FLAGS    12'h2c1
`define AMTT_ADDR_ALARM_SOURCE_MASK      12'h2c2
`define AMTT_ADDR_LANE_LO       12'h2c4
`define AMTT_ADDR_LANE_HI       12'h2c5
`define AMTT_ADDR_SUMMARY       12'h2c0
`define AMTT_ADDR_TRIM_A_DUAL   12'h310
`define AMTT_ADDR_TRIM_B_DUAL   12'h313
`define AMTT_ADDR_TRIM_A_SIN_A  12'h314
`define AMTT_ADDR_TRIM_B_SIN_A  12'h315
`define AMTT_ADDR_TRIM_A_SIN_B  12'h31a

// alarm bit positions
`define AMTT_BIT_LANE_FIFO      5
`define AMTT_BIT_LOCK_LOSS      4
`define AMTT_BIT_LINK_FAULT     3
`define AMTT_BIT_REALIGN        2
`define AMTT_BIT_OSC_PHASE      1
`define AMTT_BIT_DIV_MISMATCH   0

// reset values
`define AMTT_RST_ALARM_SOURCE_MASK       8'h3f
`define AMTT_RST_ALARM_STATUS_FLAGS     6'h3f
`define AMTT_RST_LANE_FLAGS     16'hffff
`define AMTT_RST_TRIM           8'h00

`endif

// ===== rtl/amtt_pkg.sv
package amtt_pkg;

    // operating mode of the converter cores
    typedef enum logic [1:0]
    {
        AMTT_MODE_DUAL,
        AMTT_MODE_SINGLE_FG,
        AMTT_MODE_SINGLE
    } amtt_mode_t;

    // fuse-load sequencing
    typedef enum logic [1:0]
    {
        AMTT_LD_IDLE,
        AMTT_LD_WAIT,
        AMTT_LD_DONE
    } amtt_load_state_t;

    // trim bank index
    typedef enum logic [2:0]
    {
        AMTT_TRIM_A_DUAL,
        AMTT_TRIM_B_DUAL,
        AMTT_TRIM_A_SIN_A,
        AMTT_TRIM_B_SIN_A,
        AMTT_TRIM_A_SIN_B
    } amtt_trim_idx_t;

endpackage

// ===== rtl/amtt_trim_bank.sv
`timescale 1ns/1ps
`include "amtt_defs.svh"

module amtt_trim_bank #(
    parameter int DEPTH = 5,
    parameter int WIDTH = 8
) (
    input  wire logic               clk,     // register clock
    input  wire logic               rst_n,   // async reset, low
    input  wire logic               wr_en,   // write strobe
    input  wire logic [2:0]         wr_idx,  // write entry
    input  wire logic [WIDTH-1:0]   wr_data, // write data
    input  wire logic [2:0]         rd_idx,  // read entry
    output logic      [WIDTH-1:0]   rd_data  // registered read data
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [WIDTH-1:0] rd_d;

    always_comb
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            mem_d[i] = mem_q[i];
        end
        if (wr_en && (int'(wr_idx) < DEPTH))
        begin
            mem_d[wr_idx] = wr_data;
        end
        rd_d = (int'(rd_idx) < DEPTH) ? mem_q[rd_idx] : '0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= `AMTT_RST_TRIM;
            end
            rd_data <= `AMTT_RST_TRIM;
        end
        else
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= mem_d[i];
            end
            rd_data <= rd_d;
        end
    end

endmodule

// ===== rtl/amtt_regs.sv
// Contract
// - a set mask bit keeps its alarm source out of the summary alarm
// - mask bits: lane fifo 5, lock 4, link 3, realign 2, phase 1, divider 0
// - mask register resets to 0x3f, all sources masked
// - lane i fifo overflow or underflow sets lane flag bit i
// - writing 1 clears a lane flag; writing 0 does nothing; persisting fault resets it
// - writing 1 to lane fifo status bit clears all sixteen lane flags
// - lane flag register resets to 0xffff
// - each 8-bit trim shifts one core's sampling instant, chosen by core and mode
// - trims load from fuses at start-up, readable and overwritable by software
// - dual mode: first trim to core a, second trim to core b
// - single mode with calibration: separate trims for a/in a, b/in a, a/in b; code applies a/in a and b/in a in both single modes, never a/in b
// - summary alarm is 1 when any unmasked status bit is set
// - six sticky status bits, write one to clear, reset to 0x3f
// - any lane fifo fault sets the lane fifo status bit
`timescale 1ns/1ps
`include "amtt_defs.svh"

module amtt_regs #(
    parameter int LANES = 16,
    parameter int TW    = 8
) (
    input  wire logic                clk,           // register clock
    input  wire logic                rst_n,         // async reset, low
    input  wire logic                cfg_wr,        // register write strobe
    input  wire logic                cfg_rd,        // register read strobe
    input  wire logic [11:0]         cfg_addr,      // register byte address
    input  wire logic [7:0]          cfg_wdata,     // write data
    output logic      [7:0]          cfg_rdata,     // read data, two cycles after cfg_rd
    output logic                     cfg_rvalid,    // read data valid pulse
    input  wire logic [LANES-1:0]    lane_fault,    // per-lane fifo over/underflow
    input  wire logic                lock_loss,     // pll not locked
    input  wire logic                link_fault,    // link not in data state
    input  wire logic                realign_evt,   // clocks realigned
    input  wire logic                osc_phase_evt, // oscillator phase upset
    input  wire logic                div_mismatch,  // divider mismatch
    input  wire amtt_pkg::amtt_mode_t mode,         // operating mode
    input  wire logic                fuse_valid,    // fuse word ready
    input  wire logic [5*TW-1:0]     fuse_trims,    // five factory trims
    output logic                     summary_alarm, // unmasked alarm present
    output logic      [TW-1:0]       core_a_trim,   // applied trim, core a
    output logic      [TW-1:0]       core_b_trim,   // applied trim, core b
    output logic                     trim_ready     // fuse values loaded
);

    logic [7:0]       mask_q, mask_d;
    logic [5:0]       status_q, status_d;
    logic [LANES-1:0] lane_q, lane_d;
    logic             summary_d;
    logic [TW-1:0]    a_trim_d, b_trim_d;
    logic [TW-1:0]    shadow_q [5];
    logic [TW-1:0]    shadow_d [5];
    logic [5:0]       src;
    logic             rvalid_q;
    logic [7:0]       rdata_d;
    logic             rd_trim_q, rd_trim_d;
    logic [7:0]       rd_reg_q, rd_reg_d;
    logic             rvalid_d;
    logic [TW-1:0]    bank_rdata;
    logic             bank_wr;
    logic [2:0]       bank_idx;
    logic [TW-1:0]    bank_wdata;
    logic             sw_wr;
    logic [2:0]       sw_idx;
    logic             sw_trim_hit;
    amtt_pkg::amtt_load_state_t ld_q, ld_d;
    logic [2:0]       ld_cnt_q, ld_cnt_d;
    logic             ready_d;

    logic [LANES-1:0] lane_fault_s1, lane_fault_s2;
    logic [5:0]       src_s1, src_s2;
    logic             fuse_valid_s1, fuse_valid_s2;
    logic [5*TW-1:0]  fuse_trims_s1, fuse_trims_s2;

    // fault, source and fuse inputs cross two flip-flops before use; mode is used directly
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lane_fault_s1 <= '0;
            lane_fault_s2 <= '0;
            src_s1        <= '0;
            src_s2        <= '0;
            fuse_valid_s1 <= 1'b0;
            fuse_valid_s2 <= 1'b0;
            fuse_trims_s1 <= '0;
            fuse_trims_s2 <= '0;
        end
        else
        begin
            lane_fault_s1 <= lane_fault;
            lane_fault_s2 <= lane_fault_s1;
            src_s1        <= {1'b0, lock_loss, link_fault, realign_evt,
                              osc_phase_evt, div_mismatch};
            src_s2        <= src_s1;
            fuse_valid_s1 <= fuse_valid;
            fuse_valid_s2 <= fuse_valid_s1;
            fuse_trims_s1 <= fuse_trims;
            fuse_trims_s2 <= fuse_trims_s1;
        end
    end

    always_comb
    begin
        src = src_s2;
        src[`AMTT_BIT_LANE_FIFO] = |lane_fault_s2;
    end

    // trim address decode
    always_comb
    begin
        sw_trim_hit = 1'b1;
        sw_idx      = 3'(amtt_pkg::AMTT_TRIM_A_DUAL);
        if (cfg_addr == `AMTT_ADDR_TRIM_A_DUAL)
            sw_idx = 3'(amtt_pkg::AMTT_TRIM_A_DUAL);
        else if (cfg_addr == `AMTT_ADDR_TRIM_B_DUAL)
            sw_idx = 3'(amtt_pkg::AMTT_TRIM_B_DUAL);
        else if (cfg_addr == `AMTT_ADDR_TRIM_A_SIN_A)
            sw_idx = 3'(amtt_pkg::AMTT_TRIM_A_SIN_A);
        else if (cfg_addr == `AMTT_ADDR_TRIM_B_SIN_A)
            sw_idx = 3'(amtt_pkg::AMTT_TRIM_B_SIN_A);
        else if (cfg_addr == `AMTT_ADDR_TRIM_A_SIN_B)
            sw_idx = 3'(amtt_pkg::AMTT_TRIM_A_SIN_B);
        else
            sw_trim_hit = 1'b0;
        sw_wr = cfg_wr && sw_trim_hit;
    end

    // fuse load: copies the five factory values into the bank after reset
    always_comb
    begin
        ld_d       = ld_q;
        ld_cnt_d   = ld_cnt_q;
        bank_wr    = 1'b0;
        bank_idx   = sw_idx;
        bank_wdata = cfg_wdata;
        case (ld_q)
            amtt_pkg::AMTT_LD_IDLE:
            begin
                if (fuse_valid_s2)
                    ld_d = amtt_pkg::AMTT_LD_WAIT;
            end
            amtt_pkg::AMTT_LD_WAIT:
            begin
                bank_wr    = 1'b1;
                bank_idx   = ld_cnt_q;
                bank_wdata = fuse_trims_s2[TW*ld_cnt_q +: TW];
                ld_cnt_d   = ld_cnt_q + 3'h1;
                if (ld_cnt_q == 3'h4)
                    ld_d = amtt_pkg::AMTT_LD_DONE;
            end
            default:
            begin
                bank_wr = sw_wr;
            end
        endcase
        ready_d = (ld_d == amtt_pkg::AMTT_LD_DONE);
    end

    // shadow copy so both cores see their trims in parallel
    always_comb
    begin
        for (int i = 0; i < 5; i++)
            shadow_d[i] = shadow_q[i];
        if (bank_wr)
            shadow_d[bank_idx] = bank_wdata;
    end

    // trim selection by core and mode
    always_comb
    begin
        case (mode)
            amtt_pkg::AMTT_MODE_DUAL:
            begin
                a_trim_d = shadow_q[amtt_pkg::AMTT_TRIM_A_DUAL];
                b_trim_d = shadow_q[amtt_pkg::AMTT_TRIM_B_DUAL];
            end
            default:
            begin
                a_trim_d = shadow_q[amtt_pkg::AMTT_TRIM_A_SIN_A];
                b_trim_d = shadow_q[amtt_pkg::AMTT_TRIM_B_SIN_A];
            end
        endcase
    end

    // alarm state
    always_comb
    begin
        mask_d   = mask_q;
        status_d = status_q;
        lane_d   = lane_q;
        if (cfg_wr && cfg_addr == `AMTT_ADDR_ALARM_SOURCE_MASK)
            mask_d = {2'h0, cfg_wdata[5:0]};
        if (cfg_wr && cfg_addr == `AMTT_ADDR_ALARM_STATUS_FLAGS)
        begin
            status_d = status_q & ~cfg_wdata[5:0];
            if (cfg_wdata[`AMTT_BIT_LANE_FIFO])
                lane_d = '0;
        end
        else if (cfg_wr && cfg_addr == `AMTT_ADDR_LANE_LO)
            lane_d[7:0] = lane_q[7:0] & ~cfg_wdata;
        else if (cfg_wr && cfg_addr == `AMTT_ADDR_LANE_HI)
            lane_d[15:8] = lane_q[15:8] & ~cfg_wdata;
        lane_d   = lane_d | lane_fault_s2;
        status_d = status_d | src;
        summary_d = |(status_d & ~mask_d[5:0]);
    end

    // read path
    always_comb
    begin
        rdata_d   = rd_trim_q ? bank_rdata : rd_reg_q;
        rd_trim_d = cfg_rd && sw_trim_hit;
        rvalid_d  = cfg_rd;
        rd_reg_d  = 8'h00;
        if (cfg_addr == `AMTT_ADDR_ALARM_SOURCE_MASK)
            rd_reg_d = mask_q;
        else if (cfg_addr == `AMTT_ADDR_ALARM_STATUS_FLAGS)
            rd_reg_d = {2'h0, status_q};
        else if (cfg_addr == `AMTT_ADDR_LANE_LO)
            rd_reg_d = lane_q[7:0];
        else if (cfg_addr == `AMTT_ADDR_LANE_HI)
            rd_reg_d = lane_q[15:8];
        else if (cfg_addr == `AMTT_ADDR_SUMMARY)
            rd_reg_d = {7'h00, summary_alarm};
    end

    amtt_trim_bank #(
        .DEPTH (5),
        .WIDTH (TW)
    ) u_bank (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (bank_wr),
        .wr_idx  (bank_idx),
        .wr_data (bank_wdata),
        .rd_idx  (sw_idx),
        .rd_data (bank_rdata)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_q        <= `AMTT_RST_ALARM_SOURCE_MASK;
            status_q      <= `AMTT_RST_ALARM_STATUS_FLAGS;
            lane_q        <= `AMTT_RST_LANE_FLAGS;
            summary_alarm <= 1'b0;
            core_a_trim   <= `AMTT_RST_TRIM;
            core_b_trim   <= `AMTT_RST_TRIM;
            trim_ready    <= 1'b0;
            ld_q          <= amtt_pkg::AMTT_LD_IDLE;
            ld_cnt_q      <= 3'h0;
            rvalid_q      <= 1'b0;
            cfg_rdata     <= 8'h00;
            rd_trim_q     <= 1'b0;
            rd_reg_q      <= 8'h00;
            cfg_rvalid    <= 1'b0;
            for (int i = 0; i < 5; i++)
                shadow_q[i] <= `AMTT_RST_TRIM;
        end
        else
        begin
            mask_q        <= mask_d;
            status_q      <= status_d;
            lane_q        <= lane_d;
            summary_alarm <= summary_d;
            core_a_trim   <= a_trim_d;
            core_b_trim   <= b_trim_d;
            trim_ready    <= ready_d;
            ld_q          <= ld_d;
            ld_cnt_q      <= ld_cnt_d;
            rvalid_q      <= rvalid_d;
            cfg_rdata     <= rdata_d;
            rd_trim_q     <= rd_trim_d;
            rd_reg_q      <= rd_reg_d;
            cfg_rvalid    <= rvalid_q;
            for (int i = 0; i < 5; i++)
                shadow_q[i] <= shadow_d[i];
        end
    end

    property p_mask_blocks;
        @(posedge clk) disable iff (!rst_n)
        (&mask_q[5:0]) |-> !summary_alarm;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked alarm leaked");

    property p_mask_reserved;
        @(posedge clk) disable iff (!rst_n)
        mask_q[7:6] == 2'h0;
    endproperty
    a_mask_reserved: assert property (p_mask_reserved) else $error("mask reserved set");

    property p_lane_set;
        @(posedge clk) disable iff (!rst_n)
        lane_fault_s2[3] |=> lane_q[3];
    endproperty
    a_lane_set: assert property (p_lane_set) else $error("lane flag not set");

    property p_lane_clear;
        @(posedge clk) disable iff (!rst_n)
        (cfg_wr && cfg_addr == `AMTT_ADDR_LANE_LO && cfg_wdata[0] && !lane_fault_s2[0])
            |=> !lane_q[0];
    endproperty
    a_lane_clear: assert property (p_lane_clear) else $error("lane w1c failed");

    property p_lane_all_clear;
        @(posedge clk) disable iff (!rst_n)
        (cfg_wr && cfg_addr == `AMTT_ADDR_ALARM_STATUS_FLAGS && cfg_wdata[5] && lane_fault_s2 == '0)
            |=> lane_q == '0;
    endproperty
    a_lane_all_clear: assert property (p_lane_all_clear) else $error("bulk clear failed");

    property p_summary;
        @(posedge clk) disable iff (!rst_n)
        ##1 summary_alarm == |($past(status_d) & ~$past(mask_d[5:0]));
    endproperty
    a_summary: assert property (p_summary) else $error("summary mismatch");

    property p_status_fifo;
        @(posedge clk) disable iff (!rst_n)
        (|lane_fault_s2) |=> status_q[5] && (lane_q != '0);
    endproperty
    a_status_fifo: assert property (p_status_fifo) else $error("fifo status not set");

    property p_dual_sel;
        @(posedge clk) disable iff (!rst_n)
        (mode == amtt_pkg::AMTT_MODE_DUAL) ##1 (mode == amtt_pkg::AMTT_MODE_DUAL)
            |-> core_b_trim == $past(shadow_q[1]);
    endproperty
    a_dual_sel: assert property (p_dual_sel) else $error("dual trim select wrong");

endmodule

// ===== test/amtt_regs_tb.sv
`timescale 1ns/1ps
`include "amtt_defs.svh"

module amtt_regs_tb;
    logic                 clk, rst_n, cfg_wr, cfg_rd, cfg_rvalid, fuse_valid;
    logic                 summary_alarm, trim_ready;
    logic [11:0]          cfg_addr;
    logic [7:0]           cfg_wdata, cfg_rdata, core_a_trim, core_b_trim, rv;
    logic [15:0]          lane_fault, lane_m;
    logic [4:0]           src;
    logic [39:0]          fuse_trims;
    logic [7:0]           mask_m;
    logic [5:0]           stat_m;
    logic [7:0]           trim_m [5];
    logic                 loaded_m;
    amtt_pkg::amtt_mode_t mode;
    int                   errors, samples_checked, i, b, seed;
    logic [11:0]          addrs [11] = '{`AMTT_ADDR_ALARM_STATUS_FLAGS, `AMTT_ADDR_ALARM_SOURCE_MASK,
        `AMTT_ADDR_LANE_LO, `AMTT_ADDR_LANE_HI, `AMTT_ADDR_SUMMARY, `AMTT_ADDR_TRIM_A_DUAL,
        `AMTT_ADDR_TRIM_B_DUAL, `AMTT_ADDR_TRIM_A_SIN_A, `AMTT_ADDR_TRIM_B_SIN_A,
        `AMTT_ADDR_TRIM_A_SIN_B, 12'h2c3};

    amtt_regs dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .lane_fault(lane_fault), .lock_loss(src[4]),
        .link_fault(src[3]), .realign_evt(src[2]), .osc_phase_evt(src[1]),
        .div_mismatch(src[0]), .mode(mode), .fuse_valid(fuse_valid),
        .fuse_trims(fuse_trims), .summary_alarm(summary_alarm),
        .core_a_trim(core_a_trim), .core_b_trim(core_b_trim), .trim_ready(trim_ready));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] ef(input logic [11:0] a);
        case (a)
            `AMTT_ADDR_SUMMARY:     ef = {7'h00, |(stat_m & ~mask_m[5:0])};
            `AMTT_ADDR_ALARM_STATUS_FLAGS:  ef = {2'b00, stat_m};
            `AMTT_ADDR_ALARM_SOURCE_MASK:    ef = mask_m;
            `AMTT_ADDR_LANE_LO:     ef = lane_m[7:0];
            `AMTT_ADDR_LANE_HI:     ef = lane_m[15:8];
            `AMTT_ADDR_TRIM_A_DUAL: ef = trim_m[0];
            `AMTT_ADDR_TRIM_B_DUAL: ef = trim_m[1];
            `AMTT_ADDR_TRIM_A_SIN_A: ef = trim_m[2];
            `AMTT_ADDR_TRIM_B_SIN_A: ef = trim_m[3];
            `AMTT_ADDR_TRIM_A_SIN_B: ef = trim_m[4];
            default:                ef = 8'h00;
        endcase
    endfunction

    // held fault inputs keep setting their flags
    task automatic refresh();
        lane_m = lane_m | lane_fault;
        stat_m = stat_m | {|lane_fault, src};
    endtask

    task automatic model_reset();
        mask_m   = `AMTT_RST_ALARM_SOURCE_MASK;
        stat_m   = `AMTT_RST_ALARM_STATUS_FLAGS;
        lane_m   = `AMTT_RST_LANE_FLAGS;
        loaded_m = 1'b0;
        for (int k = 0; k < 5; k++)
            trim_m[k] = `AMTT_RST_TRIM;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_wr    <= 1'b1;
        cfg_addr  <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
        case (a)
            `AMTT_ADDR_ALARM_STATUS_FLAGS:
            begin
                stat_m = stat_m & ~d[5:0];
                if (d[5])
                    lane_m = 16'h0000;
            end
            `AMTT_ADDR_ALARM_SOURCE_MASK: mask_m = {2'b00, d[5:0]};
            `AMTT_ADDR_LANE_LO:  lane_m[7:0] = lane_m[7:0] & ~d;
            `AMTT_ADDR_LANE_HI:  lane_m[15:8] = lane_m[15:8] & ~d;
            default:
                for (int k = 0; k < 5; k++)
                    if (a == addrs[5+k] && loaded_m)
                        trim_m[k] = d;
        endcase
        refresh();
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        cfg_rd   <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        d = 8'hxx;
        for (int n = 0; n < 4; n++)
        begin
            #1;
            if (cfg_rvalid === 1'b1)
            begin
                d = cfg_rdata;
                break;
            end
            @(posedge clk);
        end
    endtask

    // reads every mapped place plus one unmapped, then the summary pin
    task automatic rd_all();
        for (int k = 0; k < 11; k++)
        begin
            rd(addrs[k], rv);
            chk(rv, ef(addrs[k]));
        end
        chk(summary_alarm, ef(`AMTT_ADDR_SUMMARY));
        @(posedge clk);
    endtask

    task automatic fuse_load();
        for (int n = 0; n < 200 && trim_ready !== 1'b1; n++)
            @(posedge clk);
        #1;
        chk(trim_ready, 1'b1);
        loaded_m = 1'b1;
        for (int k = 0; k < 5; k++)
            trim_m[k] = fuse_trims[8*k +: 8];
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end

    initial
    begin
        rst_n = 1'b0; cfg_wr = 1'b0; cfg_rd = 1'b0; cfg_addr = 12'h000;
        cfg_wdata = 8'h00; lane_fault = 16'h0000; src = 5'h00; fuse_valid = 1'b0;
        fuse_trims = 40'h0; mode = amtt_pkg::AMTT_MODE_DUAL;
        seed = $urandom(47054);
        model_reset();
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd_all();
        wr(`AMTT_ADDR_TRIM_A_DUAL, 8'h5a);
        wr(12'h2c3, 8'hff);
        fuse_trims <= 40'({$urandom, $urandom});
        fuse_valid <= 1'b1;
        fuse_load();
        rd_all();
        for (i = 0; i < 5; i++)
            wr(addrs[5+i], 8'($urandom));
        rd_all();
        for (i = 0; i < 3; i++)
        begin
            mode <= amtt_pkg::amtt_mode_t'(i);
            repeat (3) @(posedge clk);
            #1;
            chk(core_a_trim, (i == 0) ? trim_m[0] : trim_m[2]);
            chk(core_b_trim, (i == 0) ? trim_m[1] : trim_m[3]);
            @(posedge clk);
        end
        wr(`AMTT_ADDR_LANE_LO, 8'h0f);
        wr(`AMTT_ADDR_LANE_HI, 8'h00);
        wr(`AMTT_ADDR_ALARM_STATUS_FLAGS, 8'h1f);
        rd_all();
        wr(`AMTT_ADDR_ALARM_STATUS_FLAGS, 8'h20);
        rd_all();
        wr(`AMTT_ADDR_ALARM_SOURCE_MASK, 8'h00);
        for (b = 0; b < 5; b++)
        begin
            src <= 5'(1 << b);
            repeat (6) @(posedge clk);
            refresh();
            rd_all();
            wr(`AMTT_ADDR_ALARM_SOURCE_MASK, 8'(1 << b));
            rd_all();
            src <= 5'h00;
            repeat (6) @(posedge clk);
            wr(`AMTT_ADDR_ALARM_SOURCE_MASK, 8'h00);
            wr(`AMTT_ADDR_ALARM_STATUS_FLAGS, 8'(1 << b));
            rd_all();
        end
        for (b = 0; b < 3; b++)
        begin
            i = $urandom % 16;
            lane_fault <= 16'(1 << i);
            repeat (6) @(posedge clk);
            refresh();
            rd_all();
            wr((i < 8) ? `AMTT_ADDR_LANE_LO : `AMTT_ADDR_LANE_HI, 8'hff);
            wr(`AMTT_ADDR_ALARM_SOURCE_MASK, 8'h20);
            rd_all();
            lane_fault <= 16'h0000;
            repeat (6) @(posedge clk);
            wr(`AMTT_ADDR_ALARM_STATUS_FLAGS, 8'h20);
            wr(`AMTT_ADDR_ALARM_SOURCE_MASK, 8'h00);
            rd_all();
        end
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        model_reset();
        rst_n <= 1'b1;
        fuse_load();
        rd_all();
        results();
    end
endmodule
